// [design/bce_des_if.sv]
// block cipher engine: operands and result of the 64-bit round unit
// assumes the core drives operands and samples the result in one cycle
`timescale 1ns/1ps
interface bce_des_if;
  logic [63:0] data;
  logic [63:0] key;
  logic [3:0]  rnd;
  logic        dec;
  logic [63:0] res;
  modport core (output data, output key, output rnd, output dec,
                input res);
  modport unit (input data, input key, input rnd, input dec,
                output res);
endinterface : bce_des_if

// [design/bce_des_round.sv]
// block cipher engine: one round of the 64-bit cipher, purely combinational
// assumes the caller registers the result in the same cycle
`timescale 1ns/1ps
module bce_des_round (
  bce_des_if.unit des
);
  import bce_pkg::*;

  logic [63:0] rk;
  logic [63:0] f_r;
  logic [63:0] f_l;

  assign rk  = des.key ^ {60'h0, des.rnd};
  assign f_r = bce_f({32'h0, des.data[31:0]}, rk);
  assign f_l = bce_f({32'h0, des.data[63:32]}, rk);

  // decrypt undoes one encrypt step with the same round number
  assign des.res = des.dec ? {des.data[31:0] ^ f_l[31:0], des.data[63:32]}
                           : {des.data[31:0], des.data[63:32] ^ f_r[31:0]};
endmodule : bce_des_round

// [design/bce_pkg.sv]
// block cipher engine: shared constants, state type and mixing functions
// assumes one 10 MHz clock; the peripheral clock equals the system clock
package bce_pkg;

  localparam int            CYC_OP    = 375;
  localparam logic [8:0]    CNT_LAST  = 9'(CYC_OP - 1);
  localparam logic [8:0]    NUM_RND   = 9'h010;
  localparam logic [3:0]    LAST_BYTE = 4'hf;
  localparam logic [127:0]  RST_KEY   = 128'h0;
  localparam logic [127:0]  RST_STATE = 128'h0;

  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_RUN  = 1'b1
  } bce_fsm_t;

  typedef struct packed {
    bce_fsm_t       fsm;
    logic [127:0]   key;
    logic [127:0]   st;
    logic [8:0]     cnt;
    logic           dec;
    logic           done;
    logic           irq;
    logic           trig;
    logic [7:0]     rdata;
    logic [63:0]    des_res;
    logic           des_vld;
  } bce_core_t;

  // round function: the add gives the nonlinear carry mixing
  function automatic logic [63:0] bce_f(input logic [63:0] r,
                                        input logic [63:0] k);
    logic [63:0] t;
    t = r ^ k;
    t = t + {t[31:0], t[63:32]};
    return {t[50:0], t[63:51]} ^ (t >> 7);
  endfunction : bce_f

  // round key: key rotated by one byte per round, round number folded in
  function automatic logic [63:0] bce_rkey(input logic [127:0] key,
                                           input logic [3:0]   idx);
    logic [255:0] d;
    d = {key, key};
    return d[{idx, 3'h0} +: 64] ^ {60'h0, idx};
  endfunction : bce_rkey

  function automatic logic [7:0] bce_byte(input logic [127:0] v,
                                          input logic [3:0]   a);
    return v[{a, 3'h0} +: 8];
  endfunction : bce_byte

endpackage : bce_pkg

// [design/bce_top.sv]
// block cipher engine: 128-bit block transform with byte-wide key and
// state memories, completion flag, interrupt, dma trigger, round instruction
// assumes writers load the whole key and state before starting
`timescale 1ns/1ps
module bce_top (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         key_we_i,
  input  wire logic [3:0]   key_addr_i,
  input  wire logic [7:0]   key_wdata_i,
  input  wire logic         st_we_i,
  input  wire logic [3:0]   st_waddr_i,
  input  wire logic [7:0]   st_wdata_i,
  input  wire logic [3:0]   st_raddr_i,
  output logic      [7:0]   st_rdata_o,
  input  wire logic         start_i,
  input  wire logic         dec_i,
  input  wire logic         auto_start_i,
  input  wire logic         xor_load_i,
  input  wire logic         irq_en_i,
  output logic              busy_o,
  output logic              done_o,
  output logic              irq_o,
  output logic              dma_trig_o,
  input  wire logic         des_exec_i,
  input  wire logic         des_dec_i,
  input  wire logic [3:0]   des_rnd_i,
  input  wire logic [63:0]  des_data_i,
  input  wire logic [63:0]  des_key_i,
  output logic      [63:0]  des_res_o,
  output logic              des_vld_o
);
  import bce_pkg::*;

  bce_core_t    q_ff;
  bce_core_t    nxt_q;
  logic         start;
  logic         finish;
  logic [3:0]   ridx;
  logic [63:0]  fk;
  logic [63:0]  f_r;
  logic [63:0]  f_l;
  logic [7:0]   wbyte;

  bce_des_if des ();

  bce_des_round u_round (
    .des (des.unit)
  );

  assign des.data = des_data_i;
  assign des.key  = des_key_i;
  assign des.rnd  = des_rnd_i;
  assign des.dec  = des_dec_i;

  // decrypt walks the round keys backwards
  assign ridx = q_ff.dec ? 4'(4'hf - q_ff.cnt[3:0]) : q_ff.cnt[3:0];
  assign fk   = bce_rkey(q_ff.key, ridx);
  assign f_r  = bce_f(q_ff.st[63:0], fk);
  assign f_l  = bce_f(q_ff.st[127:64], fk);

  assign finish = (q_ff.fsm == S_RUN) && (q_ff.cnt == CNT_LAST);
  assign wbyte  = xor_load_i ? (bce_byte(q_ff.st, st_waddr_i) ^ st_wdata_i)
                             : st_wdata_i;

  always_comb begin
    nxt_q         = q_ff;
    start         = 1'b0;
    nxt_q.trig    = 1'b0;
    nxt_q.des_vld = des_exec_i;
    // result hidden while the block is being transformed
    nxt_q.rdata   = (q_ff.fsm == S_RUN) ? 8'h00
                                        : bce_byte(q_ff.st, st_raddr_i);
    if (des_exec_i) begin
      nxt_q.des_res = des.res;
    end
    unique case (q_ff.fsm)
      S_IDLE: begin
        // memories are frozen during a run, so a late write cannot corrupt it
        if (key_we_i) begin
          nxt_q.key[{key_addr_i, 3'h0} +: 8] = key_wdata_i;
        end
        if (st_we_i) begin
          nxt_q.st[{st_waddr_i, 3'h0} +: 8] = wbyte;
          if (auto_start_i && (st_waddr_i == LAST_BYTE)) begin
            start = 1'b1;
          end
        end
        if (start_i) begin
          start = 1'b1;
        end
        if (start) begin
          nxt_q.fsm  = S_RUN;
          nxt_q.cnt  = 9'h000;
          nxt_q.dec  = dec_i;
          nxt_q.done = 1'b0;
          nxt_q.irq  = 1'b0;
        end
      end
      S_RUN: begin
        if (q_ff.cnt < NUM_RND) begin
          nxt_q.st = q_ff.dec ? {q_ff.st[63:0] ^ f_l, q_ff.st[127:64]}
                              : {q_ff.st[63:0], q_ff.st[127:64] ^ f_r};
        end
        if (finish) begin
          nxt_q.fsm  = S_IDLE;
          nxt_q.done = 1'b1;
          nxt_q.irq  = irq_en_i;
          nxt_q.trig = 1'b1;
        end else begin
          nxt_q.cnt = 9'(q_ff.cnt + 9'h001);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign st_rdata_o = q_ff.rdata;
  assign busy_o     = (q_ff.fsm == S_RUN);
  assign done_o     = q_ff.done;
  assign irq_o      = q_ff.irq;
  assign dma_trig_o = q_ff.trig;
  assign des_res_o  = q_ff.des_res;
  assign des_vld_o  = q_ff.des_vld;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  logic [8:0] run_len_ff;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_len_ff <= 9'h000;
    end else if (start) begin
      run_len_ff <= 9'h000;
    end else if (busy_o) begin
      run_len_ff <= 9'(run_len_ff + 9'h001);
    end
  end

  // the untouched half moves across: left in encrypt, right in decrypt
  property p_swap_step;
    (busy_o && q_ff.cnt == 9'h000) |=>
      (q_ff.dec ? (q_ff.st[63:0] == $past(q_ff.st[127:64]))
                : (q_ff.st[127:64] == $past(q_ff.st[63:0])));
  endproperty
  a_swap_step: assert property (p_swap_step)
    else $error("first round did not move the untouched half across");

  property p_done_time;
    $rose(done_o) |-> (run_len_ff == 9'(CYC_OP)) && !busy_o;
  endproperty
  a_done_time: assert property (p_done_time)
    else $error("done rose after the wrong number of cycles");

  property p_hidden;
    busy_o |=> (st_rdata_o == 8'h00) && (done_o != busy_o);
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("result visible before completion");

  property p_irq;
    finish |=> (irq_o == $past(irq_en_i)) && done_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow its enable at completion");

  sequence s_trig_pulse;
    dma_trig_o ##1 !dma_trig_o;
  endsequence
  property p_trig;
    finish |=> s_trig_pulse;
  endproperty
  a_trig: assert property (p_trig)
    else $error("dma trigger is not a single pulse at completion");

  // run length itself is counted in run_len_ff and checked at completion
  property p_auto;
    (!busy_o && st_we_i && auto_start_i && st_waddr_i == LAST_BYTE)
      |=> busy_o && (run_len_ff == 9'h000) && (q_ff.cnt == 9'h000);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto-start did not run a full operation");

  property p_xor;
    (!busy_o && st_we_i && xor_load_i) |=>
      bce_byte(q_ff.st, $past(st_waddr_i)) ==
      ($past(bce_byte(q_ff.st, st_waddr_i)) ^ $past(st_wdata_i));
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor load did not combine with the old byte");

  property p_des;
    des_exec_i |=> des_vld_o && (des_res_o == $past(des.res)) &&
      ($past(des_dec_i) ? (des_res_o[31:0] == $past(des_data_i[63:32]))
                        : (des_res_o[63:32] == $past(des_data_i[31:0])));
  endproperty
  a_des: assert property (p_des)
    else $error("round instruction result not ready after one cycle");

  property p_clear;
    start |=> !done_o && !irq_o && busy_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("done flag not cleared by a start");

endmodule : bce_top

// [dv/bce_host.sv]
// host model: cpu or dma side loading the key and state memories
// assumes the bench calls its tasks from a single process
`timescale 1ns/1ps
module bce_host (
  input  wire logic       clk_sys_i,
  output logic            key_we_o,
  output logic            st_we_o,
  output logic [3:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    key_we_o = 1'b0;
    st_we_o  = 1'b0;
    addr_o   = 4'h0;
    wdata_o  = 8'h00;
  end
  task automatic wr(input logic k, input logic [3:0] a,
                    input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    key_we_o = k;
    st_we_o  = !k;
    addr_o   = a;
    wdata_o  = d;
    @(posedge clk_sys_i);
    #1;
    key_we_o = 1'b0;
    st_we_o  = 1'b0;
    // released bus shows the inverse so stale data is never trusted
    wdata_o  = ~d;
  endtask : wr
  // whole unit written before any start, byte i is bits 8i+7:8i
  task automatic load(input logic k, input logic [127:0] v);
    for (int i = 0; i < 16; i++) begin
      wr(k, 4'(i), v[8*i +: 8]);
    end
  endtask : load
endmodule : bce_host

// [dv/tb_bce_top.sv]
// testbench: block cipher engine with a host model on the memory side
// assumes a 10 MHz clock; every wait is a bounded loop
`timescale 1ns/1ps
module tb_bce_top;
  localparam logic [127:0] KEY = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
  logic         clk_sys_i = 1'b0, rstn_i = 1'b0;
  logic         key_we_i, st_we_i;
  logic [3:0]   addr, st_raddr_i = 4'h0, des_rnd_i = 4'h0;
  logic [7:0]   wdata, st_rdata_o;
  logic         start_i = 1'b0, dec_i = 1'b0, auto_start_i = 1'b0;
  logic         xor_load_i = 1'b0, irq_en_i = 1'b0;
  logic         des_exec_i = 1'b0, des_dec_i = 1'b0;
  logic [63:0]  des_data_i = 64'h0, des_key_i = 64'h0, des_res_o;
  logic         busy_o, done_o, irq_o, dma_trig_o, des_vld_o;
  logic [127:0] ct, rb;
  int           miscompares = 0, cmp_count = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  bce_host u_host (.clk_sys_i, .key_we_o(key_we_i), .st_we_o(st_we_i),
    .addr_o(addr), .wdata_o(wdata));
  bce_top u_dut (.clk_sys_i, .rstn_i, .key_we_i, .key_addr_i(addr),
    .key_wdata_i(wdata), .st_we_i, .st_waddr_i(addr), .st_wdata_i(wdata),
    .st_raddr_i, .st_rdata_o, .start_i, .dec_i, .auto_start_i,
    .xor_load_i, .irq_en_i, .busy_o, .done_o, .irq_o, .dma_trig_o,
    .des_exec_i, .des_dec_i, .des_rnd_i, .des_data_i, .des_key_i,
    .des_res_o, .des_vld_o);
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_val(input logic [127:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask : step
  task automatic rd_blk(output logic [127:0] v);
    for (int i = 0; i < 16; i++) begin
      st_raddr_i = 4'(i);
      step();
      v[8*i +: 8] = st_rdata_o;
    end
  endtask : rd_blk
  // go low: the run was already launched by the last state write
  task automatic run_op(input logic go, dec, irq);
    int n;
    n = 0;
    if (go) begin
      dec_i = dec;
      start_i = 1'b1;
      step();
      start_i = 1'b0;
    end
    chk_bit(busy_o, 1'b1);
    chk_bit(done_o, 1'b0);
    chk_bit(irq_o, 1'b0);
    while (busy_o === 1'b1 && n < 400) begin
      if (n == 100) chk_val(128'(st_rdata_o), 128'h0);
      step();
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      give_verdict();
    end
    chk_val(128'(n), 128'h177);
    chk_bit(done_o, 1'b1);
    chk_bit(dma_trig_o, 1'b1);
    chk_bit(irq_o, irq);
    step();
    chk_bit(dma_trig_o, 1'b0);
  endtask : run_op
  task automatic t_aes();
    u_host.load(1'b1, KEY);
    u_host.load(1'b0, PT);
    irq_en_i = 1'b1;
    run_op(1'b1, 1'b0, 1'b1);
    rd_blk(ct);
    chk_bit(ct !== PT, 1'b1);
    u_host.load(1'b0, ct);
    run_op(1'b1, 1'b1, 1'b1);
    rd_blk(rb);
    chk_val(rb, PT);
    $display("test aes round trip done");
  endtask : t_aes
  task automatic t_auto_xor();
    irq_en_i = 1'b0;
    dec_i = 1'b0;
    xor_load_i = 1'b1;
    u_host.wr(1'b0, 4'h0, 8'h0f);
    xor_load_i = 1'b0;
    rd_blk(rb);
    chk_val(rb, PT ^ 128'h0f);
    auto_start_i = 1'b1;
    u_host.load(1'b0, PT);
    run_op(1'b0, 1'b0, 1'b0);
    auto_start_i = 1'b0;
    rd_blk(rb);
    chk_val(rb, ct);
    $display("test auto start and xor load done");
  endtask : t_auto_xor
  task automatic t_des();
    logic [63:0] cur;
    cur = 64'h0123456789abcdef;
    des_key_i = 64'h5a3c96e1f00f1e2d;
    for (int r = 0; r < 32; r++) begin
      des_exec_i = 1'b1;
      des_dec_i = (r > 15);
      des_rnd_i = (r < 16) ? 4'(r) : 4'(31 - r);
      des_data_i = cur;
      step();
      chk_bit(des_vld_o, 1'b1);
      if (r < 16) begin
        chk_val(128'(des_res_o[63:32]), 128'(cur[31:0]));
      end else begin
        chk_val(128'(des_res_o[31:0]), 128'(cur[63:32]));
      end
      cur = des_res_o;
    end
    des_exec_i = 1'b0;
    step();
    chk_bit(des_vld_o, 1'b0);
    chk_val(128'(cur), 128'h0123456789abcdef);
    $display("test round instruction done");
  endtask : t_des
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    rstn_i = 1'b1;
    t_aes();
    t_auto_xor();
    t_des();
    give_verdict();
  end
endmodule : tb_bce_top
